// ==== core/mosc_cnt_if.sv ====
// Link between the control core and the stabilisation counter.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
interface mosc_cnt_if #(parameter int NSTAT = 5, parameter int SW = 3);
   logic restart;
   logic run;
   logic ext;
   logic [SW-1:0] sel;
   logic [NSTAT-1:0] status;
   logic done;
   modport ctrl (output restart, output run, output ext, output sel, input status, input done);
   modport cnt (input restart, input run, input ext, input sel, output status, output done);
endinterface

// ==== core/mosc_counter.sv ====
// Stabilisation time counter with sticky elapsed-time status bits.
// Assumes restart is a one-cycle pulse and sel never exceeds NSTAT-1.
`timescale 1ns/100ps
module mosc_counter #(
   parameter int NSTAT = 5,
   parameter int BASE_LOG2 = 11
) (
   input wire logic clk_i,
   input wire logic rst_i,
   mosc_cnt_if.cnt port_if
);
   localparam int CW = BASE_LOG2 + NSTAT;

   typedef struct packed {
      logic [CW-1:0] count;
      logic [NSTAT-1:0] status;
      logic done;
   } mosc_cstate_s;

   mosc_cstate_s st_reg;
   mosc_cstate_s st_next;
   logic [CW-1:0] count_inc;
   logic [NSTAT-1:0] hit;

   if (NSTAT < 1 || NSTAT > 8 || BASE_LOG2 < 1) begin : g_chk
      $error("mosc_counter: unsupported size");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Each status bit fires the first time the count crosses its power of two
   assign count_inc = st_reg.count + {{(CW-1){1'b0}}, 1'b1};
   for (genvar k = 0; k < NSTAT; k++) begin : g_hit
      assign hit[k] = count_inc[BASE_LOG2 + k];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      st_next = st_reg;
      if (port_if.restart) begin
         st_next = '0;
      end else if (port_if.ext) begin
         st_next.done = 1'b1; // No wait for a driven clock
      end else if (port_if.run && !st_reg.done) begin
         st_next.count = count_inc;
         st_next.status = st_reg.status | hit; // Sticky, in order
         st_next.done = st_next.status[port_if.sel]; // Halt at the selected time
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign port_if.status = st_reg.status;
   assign port_if.done = st_reg.done;
endmodule

// ==== core/mosc_ctrl.sv ====
// Top of the main oscillator stabilisation control: register port, pin mode,
// oscillator enable, power-up delay and interrupt.
// Assumes osc_started_i and the supply detector inputs are asynchronous,
// stop_i comes from CPU logic on clk_i.
`timescale 1ns/100ps
module mosc_ctrl #(
   parameter int POR_MIN_CYCLES = mosc_pkg::POR_MIN_CYC,
   parameter int POR_MAX_CYCLES = mosc_pkg::POR_MAX_CYC,
   parameter int STAB_BASE_LOG2 = mosc_pkg::STAB_BASE_LOG2
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [mosc_pkg::ADDR_W-1:0] addr_i,
   input wire logic [mosc_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [mosc_pkg::DATA_W-1:0] rdata_o,
   input wire logic stop_i,
   input wire logic osc_started_i,
   input wire logic supply_low_ok_i,
   input wire logic supply_high_ok_i,
   output logic osc_enable_o,
   output logic hs_clock_ready_o,
   output logic crystal_osc_clock_mode_o,
   output logic crystal_osc_output_pin_mode_o,
   output logic por_release_o,
   output logic irq_o
);
   localparam int PCW = $clog2(POR_MAX_CYCLES + 1);
   localparam int NS = mosc_pkg::NUM_STAT;
   localparam int DW = mosc_pkg::DATA_W;

   if (POR_MIN_CYCLES < 1 || POR_MAX_CYCLES < POR_MIN_CYCLES || STAB_BASE_LOG2 < 1) begin : g_chk
      $error("mosc_ctrl: unsupported timing parameters");
   end

   typedef enum logic [2:0] {
      POR_OFF = 3'h1,
      POR_WAIT = 3'h2,
      POR_DONE = 3'h4
   } mosc_por_e;

   typedef struct packed {
      logic [2:0] sync1;
      logic [2:0] sync2;
      logic [mosc_pkg::SEL_W-1:0] stab_time_select;
      logic ext_hs_clock_select;
      logic hs_osc_pin_mode_select;
      logic [1:0] irq_status;
      logic [1:0] irq_mask;
      logic [DW-1:0] rdata;
      mosc_por_e por_state;
      logic [PCW-1:0] por_cnt;
      logic por_release;
      logic osc_en;
      logic restart;
      logic done_prev;
      logic hs_ready;
      logic pin_x1;
      logic pin_x2;
      logic irq;
   } mosc_state_s;

   mosc_state_s st_reg;
   mosc_state_s st_next;

   mosc_cnt_if #(.NSTAT(NS), .SW(mosc_pkg::SEL_W)) cnt_if ();

   ////////////////////////////////////////////////////////////////////////////
   // Stabilisation counter
   mosc_counter #(
      .NSTAT(NS),
      .BASE_LOG2(STAB_BASE_LOG2)
   ) i_mosc_counter (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .port_if(cnt_if)
   );

   // Counting waits for the oscillator's own start report
   assign cnt_if.restart = st_reg.restart;
   assign cnt_if.run = st_reg.osc_en & st_reg.sync2[0];
   assign cnt_if.ext = st_reg.ext_hs_clock_select;
   assign cnt_if.sel = st_reg.stab_time_select;

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      logic wait_busy;
      logic cfg_locked;
      logic [1:0] irq_set;
      logic [1:0] irq_clr;
      logic osc_en_next;
      wait_busy = 1'b0;
      cfg_locked = 1'b0;
      irq_set = 2'h0;
      irq_clr = 2'h0;
      osc_en_next = 1'b0;
      st_next = st_reg;

      // Two-flop synchronisers: bit 0 started, 1 low supply, 2 high supply
      st_next.sync1 = {supply_high_ok_i, supply_low_ok_i, osc_started_i};
      st_next.sync2 = st_reg.sync1;

      // A select change mid-wait would move the goal post, so it is dropped
      wait_busy = st_reg.osc_en & ~cnt_if.done;
      // Source and pin mode only change with the crystal stopped
      cfg_locked = st_reg.osc_en;

      // Register writes
      if (wr_i) begin
         case (addr_i)
            mosc_pkg::OFS_STAB_SEL: begin
               if (!wait_busy) begin
                  if (wdata_i[mosc_pkg::SEL_W-1:0] > 3'(NS - 1)) begin
                     st_next.stab_time_select = 3'(NS - 1);
                  end else begin
                     st_next.stab_time_select = wdata_i[mosc_pkg::SEL_W-1:0];
                  end
               end
            end
            mosc_pkg::OFS_CLK_CFG: begin
               if (!cfg_locked) begin
                  st_next.hs_osc_pin_mode_select = wdata_i[mosc_pkg::CFG_PIN_BIT];
                  st_next.ext_hs_clock_select = wdata_i[mosc_pkg::CFG_EXT_BIT];
               end
            end
            mosc_pkg::OFS_IRQ_STATUS: begin
               irq_clr = wdata_i[1:0];
            end
            mosc_pkg::OFS_IRQ_MASK: begin
               st_next.irq_mask = wdata_i[1:0];
            end
            default: begin
            end
         endcase
      end

      // Read data stand for exactly one cycle; unmapped reads give zero
      st_next.rdata = '0;
      if (rd_i) begin
         case (addr_i)
            mosc_pkg::OFS_STAB_SEL: st_next.rdata = DW'(st_reg.stab_time_select);
            mosc_pkg::OFS_STAB_STATUS: st_next.rdata = DW'(cnt_if.status);
            mosc_pkg::OFS_CLK_CFG: st_next.rdata = DW'({st_reg.ext_hs_clock_select, st_reg.hs_osc_pin_mode_select});
            mosc_pkg::OFS_IRQ_STATUS: st_next.rdata = DW'(st_reg.irq_status);
            mosc_pkg::OFS_IRQ_MASK: st_next.rdata = DW'(st_reg.irq_mask);
            default: st_next.rdata = '0;
         endcase
      end

      ////////////////////////////////////////////////////////////////////////
      // Power-up delay: at least the minimum after the low threshold, then
      // wait for the high threshold, but never beyond the maximum
      case (st_reg.por_state)
         POR_OFF: begin
            st_next.por_cnt = '0;
            st_next.por_release = 1'b0;
            if (st_reg.sync2[1]) begin
               st_next.por_state = POR_WAIT;
            end
         end
         POR_WAIT: begin
            st_next.por_cnt = st_reg.por_cnt + PCW'(1);
            if (!st_reg.sync2[1]) begin
               st_next.por_state = POR_OFF;
            end else if ((st_reg.por_cnt >= PCW'(POR_MIN_CYCLES - 1) && st_reg.sync2[2]) ||
                         st_reg.por_cnt >= PCW'(POR_MAX_CYCLES - 1)) begin
               st_next.por_state = POR_DONE;
               st_next.por_release = 1'b1;
               irq_set[mosc_pkg::IRQ_POR_BIT] = 1'b1;
            end
         end
         POR_DONE: begin
            // A brown-out below the low threshold starts the delay over
            if (!st_reg.sync2[1]) begin
               st_next.por_state = POR_OFF;
               st_next.por_release = 1'b0;
            end
         end
         default: begin
            st_next.por_state = POR_OFF;
            st_next.por_release = 1'b0;
         end
      endcase

      ////////////////////////////////////////////////////////////////////////
      // Crystal runs only in oscillator pin mode, without an external clock,
      // outside stop and after power-up; each rise restarts the count
      osc_en_next = st_reg.hs_osc_pin_mode_select & ~st_reg.ext_hs_clock_select &
                    ~stop_i & st_reg.por_release;
      st_next.osc_en = osc_en_next;
      st_next.restart = osc_en_next & ~st_reg.osc_en;

      // An external clock is usable at once; a crystal only after its wait
      st_next.hs_ready = st_reg.hs_osc_pin_mode_select & ~stop_i &
                         (st_reg.ext_hs_clock_select | (st_reg.osc_en & cnt_if.done & ~st_reg.restart));

      // Stabilisation complete event
      st_next.done_prev = cnt_if.done;
      if (cnt_if.done && !st_reg.done_prev) begin
         irq_set[mosc_pkg::IRQ_STAB_BIT] = 1'b1;
      end

      // Pins stay port pins until software picks a clock mode
      st_next.pin_x1 = st_reg.hs_osc_pin_mode_select & ~st_reg.ext_hs_clock_select;
      st_next.pin_x2 = st_reg.hs_osc_pin_mode_select;

      // Sticky interrupt flags: a set in the clearing cycle wins
      st_next.irq_status = (st_reg.irq_status & ~irq_clr) | irq_set;
      st_next.irq = |(st_next.irq_status & st_next.irq_mask);
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; reset leaves both oscillator pins in port mode
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_reg <= '0;
         st_reg.stab_time_select <= mosc_pkg::SEL_RST;
         st_reg.por_state <= POR_OFF;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs straight from flip-flops
   assign rdata_o = st_reg.rdata;
   assign osc_enable_o = st_reg.osc_en;
   assign hs_clock_ready_o = st_reg.hs_ready;
   assign crystal_osc_clock_mode_o = st_reg.pin_x1;
   assign crystal_osc_output_pin_mode_o = st_reg.pin_x2;
   assign por_release_o = st_reg.por_release;
   assign irq_o = st_reg.irq;
endmodule

// ==== core/mosc_pkg.sv ====
// Constants for the main oscillator stabilisation control block.
// Assumes one 25 MHz system clock and a plain strobe-based register port.
package mosc_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // Register port
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [7:0] OFS_STAB_SEL = 8'h00;
   localparam logic [7:0] OFS_STAB_STATUS = 8'h04;
   localparam logic [7:0] OFS_CLK_CFG = 8'h08;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
   ////////////////////////////////////////////////////////////////////////////
   // Fields and reset values
   localparam int NUM_STAT = 5;
   localparam int SEL_W = 3;
   localparam logic [2:0] SEL_RST = 3'h4;
   localparam int CFG_PIN_BIT = 0;
   localparam int CFG_EXT_BIT = 1;
   localparam int IRQ_STAB_BIT = 0;
   localparam int IRQ_POR_BIT = 1;
   localparam int STAB_BASE_LOG2 = 11;
   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int POR_MIN_NS = 1930000;
   localparam int POR_MAX_NS = 5390000;
   localparam int POR_MIN_CYC = (POR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POR_MAX_CYC = POR_MAX_NS / CLK_PERIOD_NS;
endpackage

// ==== verification/mosc_ctrl_tb.sv ====
// Self-checking bench for the oscillator stabilisation control.
// Assumes shortened counts; a crystal model answers the oscillator enable.
`timescale 1ns/100ps
module mosc_ctrl_tb;
   localparam int PMIN = 20;
   localparam int PMAX = 50;
   localparam int BASE = 2;
   localparam int XDLY = 10;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic stop_i = 1'b1;
   logic low_ok = 1'b0;
   logic high_ok = 1'b0;
   logic rd_q = 1'b0;
   logic [7:0] rdata_o;
   logic started, osc_en, ready, pin1, pin2, por, irq_o;
   logic [2:0] s, e;
   logic [7:0] exp_q[$];
   int bad_count = 0;
   int total_checks = 0;
   int seed = 32'ha5e0f379;
   int n, cyc = 0, t0;
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   mosc_ctrl #(.POR_MIN_CYCLES(PMIN), .POR_MAX_CYCLES(PMAX), .STAB_BASE_LOG2(BASE)) i_mosc_ctrl (
      .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .stop_i(stop_i), .osc_started_i(started), .supply_low_ok_i(low_ok),
      .supply_high_ok_i(high_ok), .osc_enable_o(osc_en), .hs_clock_ready_o(ready),
      .crystal_osc_clock_mode_o(pin1), .crystal_osc_output_pin_mode_o(pin2), .por_release_o(por),
      .irq_o(irq_o));
   mosc_xtal_model #(.START_CYCLES(XDLY)) i_mosc_xtal_model (.clk_i(clk_i), .en_i(osc_en),
      .started_o(started));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Bus cycles start at a rising edge; one idle cycle follows each strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      addr_i <= a;
      rd_i <= 1'b1;
      exp_q.push_back(x);
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(posedge clk_i);
   endtask
   // Bounded wait on release, ready or enable; a timeout ends the run
   task automatic wait_for(input int which, input int lim);
      logic v;
      n = 0;
      v = 1'b0;
      while (v !== 1'b1 && n < lim) begin
         @(posedge clk_i);
         n++;
         v = (which == 0) ? por : ((which == 1) ? ready : osc_en);
      end
      if (v !== 1'b1) begin
         chk(8'h00, 8'h01);
         test_done();
      end
   endtask
   ////////////////////////////////////////////////////////////
   // Read answers are compared against the oldest queued note
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (rd_q) begin
         chk(rdata_o, exp_q.pop_front());
      end
      rd_q <= rd_i;
   end
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk({6'h00, pin1, pin2}, 8'h00);
      rd(8'h00, 8'h04);
      rd(8'h08, 8'h00);
      rd(8'h04, 8'h00);
      rd(8'h14, 8'h00);
      // Slow ramp: only the low threshold is reached, so the ceiling applies
      low_ok <= 1'b1;
      wait_for(0, 200);
      chk({7'h00, n >= PMAX && n <= PMAX + 6}, 8'h01);
      rd(8'h0c, 8'h02);
      chk({7'h00, irq_o}, 8'h00);
      wr(8'h10, 8'h03);
      @(posedge clk_i);
      chk({7'h00, irq_o}, 8'h01);
      low_ok <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk({7'h00, por}, 8'h00);
      low_ok <= 1'b1;
      high_ok <= 1'b1;
      wait_for(0, 200);
      chk({7'h00, n >= PMIN && n <= PMIN + 6}, 8'h01);
      wr(8'h08, 8'h01);
      for (int i = 0; i < 6; i++) begin
         s = 3'($random(seed));
         e = (s > 3'h4) ? 3'h4 : s;
         // Time select goes in while stopped, before the oscillator restarts
         wr(8'h00, {5'h00, s});
         rd(8'h00, {5'h00, e});
         stop_i <= 1'b0;
         wait_for(2, 10);
         t0 = cyc;
         wr(8'h00, 8'h00);
         rd(8'h00, {5'h00, e});
         wr(8'h08, 8'h03);
         rd(8'h08, 8'h01);
         rd(8'h04, 8'h00);
         wait_for(1, 400);
         n = cyc - t0 - XDLY - (1 << (BASE + e));
         chk({7'h00, n >= 0 && n <= 8}, 8'h01);
         repeat (70) @(posedge clk_i);
         rd(8'h04, (8'h02 << e) - 8'h01);
         stop_i <= 1'b1;
         @(posedge clk_i);
      end
      wr(8'h0c, 8'h03);
      @(posedge clk_i);
      chk({7'h00, irq_o}, 8'h00);
      // External clock: ready without any oscillation from the crystal
      wr(8'h08, 8'h03);
      stop_i <= 1'b0;
      wait_for(1, 6);
      chk({5'h00, pin1, pin2, osc_en}, 8'h02);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk({6'h00, pin1, pin2}, 8'h00);
      rd(8'h08, 8'h00);
      // Let the watcher take the last answer before the run ends
      @(posedge clk_i);
      test_done();
   end
endmodule

// ==== verification/mosc_monitor.sv ====
// Port checker for the oscillator stabilisation control.
// Assumes inputs change on clk_i; bound to every mosc_ctrl instance.
`timescale 1ns/100ps
module mosc_monitor #(
   parameter int POR_MIN_CYCLES = 20,
   parameter int POR_MAX_CYCLES = 50,
   parameter int STAB_BASE_LOG2 = 2
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic stop_i,
   input wire logic osc_started_i,
   input wire logic supply_low_ok_i,
   input wire logic osc_enable_o,
   input wire logic hs_clock_ready_o,
   input wire logic crystal_osc_clock_mode_o,
   input wire logic crystal_osc_output_pin_mode_o,
   input wire logic por_release_o
);
   int low_cnt;
   // Supply-good run length; saturates so the ceiling compare stays reachable
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         low_cnt <= 0;
      end else if (!supply_low_ok_i) begin
         low_cnt <= 0;
      end else if (low_cnt < POR_MAX_CYCLES + 8) begin
         low_cnt <= low_cnt + 1;
      end
   end
   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Oscillator enabled but silent long enough for the synchroniser to see it
   sequence s_osc_silent;
      (osc_enable_o && !osc_started_i) [*4] ##0 !hs_clock_ready_o;
   endsequence
   sequence s_supply_lost;
      !supply_low_ok_i [*4];
   endsequence
   property p_pins_reset;
      $fell(rst_i) |-> !crystal_osc_clock_mode_o && !crystal_osc_output_pin_mode_o;
   endproperty
   property p_osc_silent;
      s_osc_silent |=> !hs_clock_ready_o;
   endproperty
   property p_por_min;
      $rose(por_release_o) |-> low_cnt >= POR_MIN_CYCLES;
   endproperty
   property p_por_max;
      low_cnt == POR_MAX_CYCLES + 4 |-> por_release_o;
   endproperty
   property p_por_drop;
      s_supply_lost |=> !por_release_o;
   endproperty
   property p_osc_en;
      osc_enable_o |-> $past(por_release_o) && !$past(stop_i);
   endproperty
   property p_stop_ready;
      stop_i |=> !hs_clock_ready_o;
   endproperty
   property p_pin_ready;
      !crystal_osc_output_pin_mode_o [*2] |-> !hs_clock_ready_o;
   endproperty
   property p_osc_mode;
      osc_enable_o |-> crystal_osc_clock_mode_o;
   endproperty
   a_pins_reset: assert property (p_pins_reset)
      else $error("oscillator pins not in port mode after reset");
   a_osc_silent: assert property (p_osc_silent)
      else $error("clock ready before oscillation started");
   a_por_min: assert property (p_por_min)
      else $error("power-up release too early");
   a_por_max: assert property (p_por_max)
      else $error("power-up release missing at ceiling");
   a_por_drop: assert property (p_por_drop)
      else $error("power-up release kept after supply loss");
   a_osc_en: assert property (p_osc_en)
      else $error("oscillator enabled while stopped or before release");
   a_stop_ready: assert property (p_stop_ready)
      else $error("clock ready during stop");
   a_pin_ready: assert property (p_pin_ready)
      else $error("clock ready with pins in port mode");
   a_osc_mode: assert property (p_osc_mode)
      else $error("oscillator enabled without oscillator pin mode");
endmodule
bind mosc_ctrl mosc_monitor #(.POR_MIN_CYCLES(POR_MIN_CYCLES), .POR_MAX_CYCLES(POR_MAX_CYCLES),
   .STAB_BASE_LOG2(STAB_BASE_LOG2)) i_mosc_monitor (.clk_i(clk_i), .rst_i(rst_i), .stop_i(stop_i),
   .osc_started_i(osc_started_i), .supply_low_ok_i(supply_low_ok_i), .osc_enable_o(osc_enable_o),
   .hs_clock_ready_o(hs_clock_ready_o), .crystal_osc_clock_mode_o(crystal_osc_clock_mode_o),
   .crystal_osc_output_pin_mode_o(crystal_osc_output_pin_mode_o), .por_release_o(por_release_o));

// ==== verification/mosc_xtal_model.sv ====
// Crystal resonator model: reports oscillation a fixed time after enable.
// Assumes the enable comes from the block on clk_i.
`timescale 1ns/100ps
module mosc_xtal_model #(
   parameter int START_CYCLES = 10
) (
   input wire logic clk_i,
   input wire logic en_i,
   output logic started_o
);
   int cnt = 0;
   initial started_o = 1'b0;
   // Start-up interval before oscillation; stops at once when disabled
   always @(posedge clk_i) begin
      if (!en_i) begin
         cnt <= 0;
         started_o <= 1'b0;
      end else if (cnt < START_CYCLES) begin
         cnt <= cnt + 1;
      end else begin
         started_o <= 1'b1;
      end
   end
endmodule
